// [rtl/gec_counter.sv]
// Gated event counter: gate qualification, source selection and count
//
// Operation
// - Gate mode 0 ignores the gate; counting starts at the start command.
// - Gate mode 1 counts only while the gate is high, holds otherwise.
// - Gate mode 2 counts only while the gate is low, holds otherwise.
// - Gate mode 3 waits after start for a gate rising edge, then counts.
// - Gate mode 4 waits after start for a gate falling edge, then counts.
// - Source edge 0 counts rising transitions, 1 counts falling transitions.
// - Nonzero timebase divisor counts internal ticks, else external source pin.
`timescale 1ns/10ps

module gec_counter #(
  parameter int COUNT_W = gec_pkg::GEC_COUNT_W,
  parameter int DIV_W   = gec_pkg::GEC_TB_DIV_W
) (
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               start_in,
  input  wire logic               stop_in,
  input  wire logic               clear_in,
  input  wire logic [2:0]         gate_mode_in,
  input  wire logic               source_edge_in,
  input  wire logic [DIV_W-1:0]   timebase_div_in,
  input  wire logic               counter_gate_input,
  input  wire logic               counter_event_source_input,
  output logic [COUNT_W-1:0]      count_out,
  output logic                    running_out,
  output logic                    armed_out,
  output logic                    count_pulse_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  gec_pkg::gec_state_t     state_reg;
  gec_pkg::gec_state_t     state_next;
  logic [COUNT_W-1:0]      count_reg;
  logic [DIV_W-1:0]        tb_cnt_reg;
  logic                    tb_level_reg;
  logic                    running_reg;
  logic                    armed_reg;
  logic                    pulse_reg;
  logic                    use_timebase;
  logic                    cnt_sig;
  logic                    cnt_edge;
  logic                    gate_level;
  logic                    gate_rise;
  logic                    gate_fall;
  logic                    gate_ok;
  logic                    count_en;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Edge-started modes park in ARMED after the start command
  function automatic logic is_trig_mode(input logic [2:0] mode);
    logic trig;
    trig = 1'h0;
    case (mode)
      gec_pkg::GEC_GATE_RISE: trig = 1'h1;
      gec_pkg::GEC_GATE_FALL: trig = 1'h1;
      default:                trig = 1'h0;
    endcase
    return trig;
  endfunction

  // Gate edge that releases an armed counter in the given mode
  function automatic logic trig_hit(input logic [2:0] mode,
                                    input logic       rise,
                                    input logic       fall);
    logic hit;
    hit = 1'h0;
    case (mode)
      gec_pkg::GEC_GATE_RISE: hit = rise;
      gec_pkg::GEC_GATE_FALL: hit = fall;
      default:                hit = 1'h0;
    endcase
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Both gate edges are needed, so the polarity select is left fixed
  gec_edge_detect u_gate_edge (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .sig_in       (counter_gate_input),
    .fall_sel_in  (gec_pkg::GEC_EDGE_RISE),
    .level_out    (gate_level),
    .rise_out     (gate_rise),
    .fall_out     (gate_fall),
    .sel_edge_out ()
  );

  // Polarity applies to whichever signal is counted
  gec_edge_detect u_src_edge (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .sig_in       (cnt_sig),
    .fall_sel_in  (source_edge_in),
    .level_out    (),
    .rise_out     (),
    .fall_out     (),
    .sel_edge_out (cnt_edge)
  );

  // ----------------------------------------------------------------
  // Internal timebase
  // ----------------------------------------------------------------
  // Divisor zero stands for the non-positive setting: external pin
  assign use_timebase = (timebase_div_in != DIV_W'(gec_pkg::GEC_TB_DIV_OFF));
  assign cnt_sig      = use_timebase ? tb_level_reg : counter_event_source_input;

  // Square wave of period 2*divisor clocks, one rising edge per period
  // A new divisor acts from the current phase count onward
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !use_timebase) begin
      tb_cnt_reg   <= '0;
      tb_level_reg <= 1'h0;
    end else if (tb_cnt_reg + DIV_W'(gec_pkg::GEC_TB_DIV_ONE) >= timebase_div_in) begin
      tb_cnt_reg   <= '0;
      tb_level_reg <= ~tb_level_reg;
    end else begin
      tb_cnt_reg <= tb_cnt_reg + DIV_W'(gec_pkg::GEC_TB_DIV_ONE);
    end
  end

  // ----------------------------------------------------------------
  // Gate qualification
  // ----------------------------------------------------------------
  // Edge modes already waited in ARMED; they count freely once running
  always_comb begin
    case (gate_mode_in)
      gec_pkg::GEC_GATE_NONE: gate_ok = 1'h1;
      gec_pkg::GEC_GATE_HIGH: gate_ok = gate_level;
      gec_pkg::GEC_GATE_LOW:  gate_ok = ~gate_level;
      default:                gate_ok = 1'h1;
    endcase
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      gec_pkg::GEC_ST_IDLE: begin
        // A held start does nothing once the block has left IDLE
        if (start_in) begin
          if (is_trig_mode(gate_mode_in)) begin
            state_next = gec_pkg::GEC_ST_ARMED;
          end else begin
            state_next = gec_pkg::GEC_ST_RUN;
          end
        end
      end
      gec_pkg::GEC_ST_ARMED: begin
        // Stop abandons the wait without a single count
        if (stop_in) begin
          state_next = gec_pkg::GEC_ST_IDLE;
        end else if (trig_hit(gate_mode_in, gate_rise, gate_fall)) begin
          state_next = gec_pkg::GEC_ST_RUN;
        end
      end
      gec_pkg::GEC_ST_RUN: begin
        if (stop_in) begin
          state_next = gec_pkg::GEC_ST_IDLE;
        end
      end
      default: state_next = gec_pkg::GEC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= gec_pkg::GEC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  // Edge on the trigger cycle itself is not counted; counting begins after it
  // Wraps at full scale; no terminal-count flag is kept
  assign count_en = (state_reg == gec_pkg::GEC_ST_RUN) && !stop_in && gate_ok && cnt_edge;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count_reg <= COUNT_W'(gec_pkg::GEC_COUNT_ZERO);
    end else if (clear_in) begin
      count_reg <= COUNT_W'(gec_pkg::GEC_COUNT_ZERO);
    end else if (count_en) begin
      count_reg <= count_reg + COUNT_W'(gec_pkg::GEC_COUNT_STEP);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      running_reg <= 1'h0;
      armed_reg   <= 1'h0;
      pulse_reg   <= 1'h0;
    end else begin
      running_reg <= (state_next == gec_pkg::GEC_ST_RUN);
      armed_reg   <= (state_next == gec_pkg::GEC_ST_ARMED);
      // Clear wins over a count, so no step and no pulse then
      pulse_reg   <= count_en && !clear_in;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output leaves straight from a flip-flop
  assign count_out       = count_reg;
  assign running_out     = running_reg;
  assign armed_out       = armed_reg;
  assign count_pulse_out = pulse_reg;

endmodule // gec_counter

// [rtl/gec_pkg.sv]
// Package for the gated event counter: modes, widths and timing constants
package gec_pkg;

  // ----------------------------------------------------------------
  // Gate modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GEC_GATE_NONE = 3'h0,
    GEC_GATE_HIGH = 3'h1,
    GEC_GATE_LOW  = 3'h2,
    GEC_GATE_RISE = 3'h3,
    GEC_GATE_FALL = 3'h4
  } gec_gate_mode_t;

  // ----------------------------------------------------------------
  // Source edge selection
  // ----------------------------------------------------------------
  localparam logic GEC_EDGE_RISE = 1'h0;
  localparam logic GEC_EDGE_FALL = 1'h1;

  // ----------------------------------------------------------------
  // Counter state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GEC_ST_IDLE  = 2'h0,
    GEC_ST_ARMED = 2'h1,
    GEC_ST_RUN   = 2'h2
  } gec_state_t;

  // ----------------------------------------------------------------
  // Defaults and timing
  // ----------------------------------------------------------------
  localparam int          GEC_COUNT_W      = 32;
  localparam int          GEC_CLK_PERIOD_NS = 8;
  localparam int          GEC_TB_DIV_W     = 32;
  localparam logic [31:0] GEC_TB_DIV_OFF   = 32'h0000_0000;
  localparam logic [31:0] GEC_TB_DIV_ONE   = 32'h0000_0001;
  localparam logic [31:0] GEC_COUNT_ZERO   = 32'h0000_0000;
  localparam logic [31:0] GEC_COUNT_STEP   = 32'h0000_0001;

endpackage : gec_pkg

// [rtl/gec_edge_detect.sv]
// Edge detector for a synchronous input, with selectable edge
`timescale 1ns/10ps

module gec_edge_detect (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic sig_in,
  input  wire logic fall_sel_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out,
  output logic      sel_edge_out
);

  logic prev_reg;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prev_reg <= 1'h0;
    end else begin
      prev_reg <= sig_in;
    end
  end

  assign level_out    = sig_in;
  assign rise_out     = sig_in & ~prev_reg;
  assign fall_out     = ~sig_in & prev_reg;
  assign sel_edge_out = fall_sel_in ? fall_out : rise_out;

endmodule // gec_edge_detect

// [tb/gec_ttl_model.sv]
// External TTL event source and gate model for the counter
`timescale 1ns/10ps
module gec_ttl_model (
  input  wire logic clk_in,
  output logic      src_out,
  output logic      gate_out
);
  initial begin
    src_out  = 1'h0;
    gate_out = 1'h0;
  end
  // Pins move on falling edges, well clear of sampling
  task automatic toggle(input int n);
    repeat (n) @(negedge clk_in) src_out <= ~src_out;
  endtask
  task automatic set_gate(input logic v);
    @(negedge clk_in) gate_out <= v;
  endtask
endmodule // gec_ttl_model

// [tb/gec_counter_assertions.sv]
// Port checker for the gated event counter
`timescale 1ns/10ps
module gec_chk #(
  parameter int COUNT_W = 32,
  parameter int DIV_W   = 32
) (
  input wire logic               clk_in,
  input wire logic               sys_rst_in,
  input wire logic               start_in,
  input wire logic               stop_in,
  input wire logic               clear_in,
  input wire logic [2:0]         gate_mode_in,
  input wire logic               source_edge_in,
  input wire logic [DIV_W-1:0]   timebase_div_in,
  input wire logic               counter_gate_input,
  input wire logic               counter_event_source_input,
  input wire logic [COUNT_W-1:0] count_out,
  input wire logic               running_out,
  input wire logic               armed_out,
  input wire logic               count_pulse_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire idle = !running_out && !armed_out;
  count_edge_a: assert property (running_out && gate_mode_in == 3'h0 && timebase_div_in == '0
    && !stop_in && !clear_in && counter_event_source_input == !source_edge_in
    && counter_event_source_input != $past(counter_event_source_input)
    |=> count_out == $past(count_out) + 1'b1 && count_pulse_out) else $error("edge not counted");
  idle_hold_a: assert property (!running_out && !clear_in |=> $stable(count_out))
    else $error("count moved while not running");
  pulse_step_a: assert property (count_pulse_out |-> count_out == $past(count_out) + 1'b1)
    else $error("pulse without single step");
  gate_high_a: assert property (running_out && gate_mode_in == 3'h1 && !clear_in
    && !counter_gate_input && !$past(counter_gate_input) |=> $stable(count_out))
    else $error("counted with gate low");
  gate_low_a: assert property (running_out && gate_mode_in == 3'h2 && !clear_in
    && counter_gate_input && $past(counter_gate_input) |=> $stable(count_out))
    else $error("counted with gate high");
  start_run_a: assert property (idle && start_in && !stop_in && gate_mode_in <= 3'h2
    |=> running_out) else $error("start did not run");
  arm_wait_a: assert property (idle && start_in && !stop_in && gate_mode_in inside {3'h3, 3'h4}
    |=> armed_out && !running_out) else $error("start did not arm");
  gate_arm_a: assert property (armed_out && !stop_in && ((gate_mode_in == 3'h3
    && $rose(counter_gate_input)) || (gate_mode_in == 3'h4 && $fell(counter_gate_input)))
    |=> running_out && !armed_out) else $error("gate edge did not start");
  armed_hold_a: assert property (armed_out && !clear_in |=> $stable(count_out))
    else $error("counted while armed");
endmodule // gec_chk
bind gec_counter gec_chk #(.COUNT_W(COUNT_W), .DIV_W(DIV_W)) gec_chk_inst (
  .clk_in                     (clk_in),
  .sys_rst_in                 (sys_rst_in),
  .start_in                   (start_in),
  .stop_in                    (stop_in),
  .clear_in                   (clear_in),
  .gate_mode_in               (gate_mode_in),
  .source_edge_in             (source_edge_in),
  .timebase_div_in            (timebase_div_in),
  .counter_gate_input         (counter_gate_input),
  .counter_event_source_input (counter_event_source_input),
  .count_out                  (count_out),
  .running_out                (running_out),
  .armed_out                  (armed_out),
  .count_pulse_out            (count_pulse_out)
);

// [tb/tb_gec_counter.sv]
// Self-checking testbench for the gated event counter
`timescale 1ns/10ps
module tb_gec_counter;
  logic        clk_in;
  logic        sys_rst_in;
  logic        start_in;
  logic        stop_in;
  logic        clear_in;
  logic [2:0]  gate_mode_in;
  logic        source_edge_in;
  logic [31:0] timebase_div_in;
  logic        gate, src, running_out, armed_out, count_pulse_out;
  logic [31:0] count_out;
  int          n_fail = 0;
  int          checked = 0;
  always #4 clk_in = ~clk_in;
  gec_ttl_model gec_ttl_model_inst (.clk_in(clk_in), .src_out(src), .gate_out(gate));
  gec_counter gec_counter_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in),
    .stop_in(stop_in), .clear_in(clear_in), .gate_mode_in(gate_mode_in),
    .source_edge_in(source_edge_in), .timebase_div_in(timebase_div_in),
    .counter_gate_input(gate), .counter_event_source_input(src), .count_out(count_out),
    .running_out(running_out), .armed_out(armed_out), .count_pulse_out(count_pulse_out));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_in) s = 1'h1;
    @(negedge clk_in) s = 1'h0;
  endtask
  // Configure only while idle; count is zeroed last
  task automatic go(input logic [2:0] m, input logic e, input logic [31:0] d);
    gate_mode_in    = m;
    source_edge_in  = e;
    timebase_div_in = d;
    pulse(clear_in);
  endtask
  task automatic halt();
    repeat (2) @(negedge clk_in);
    pulse(stop_in);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_free();
    for (int e = 0; e < 2; e++) begin
      go(3'h0, e[0], 32'h0);
      gec_ttl_model_inst.toggle(4);
      check(count_out, 32'h0, "count before start");
      pulse(start_in);
      gec_ttl_model_inst.toggle(6);
      check(32'(running_out), 32'h1, "running");
      @(negedge clk_in);
      check(32'(count_pulse_out), 32'(e), "count pulse");
      halt();
      check(count_out, 32'h3, "free count");
    end
  endtask
  task automatic s_level();
    for (int m = 1; m < 3; m++) begin
      go(m[2:0], 1'h0, 32'h0);
      gec_ttl_model_inst.set_gate(m == 2);
      pulse(start_in);
      gec_ttl_model_inst.toggle(6);
      gec_ttl_model_inst.set_gate(m == 1);
      gec_ttl_model_inst.toggle(6);
      halt();
      check(count_out, 32'h3, "gated count");
    end
  endtask
  task automatic s_trig();
    for (int m = 3; m < 5; m++) begin
      go(m[2:0], 1'h0, 32'h0);
      gec_ttl_model_inst.set_gate(m == 4);
      pulse(start_in);
      gec_ttl_model_inst.toggle(4);
      check(32'(armed_out), 32'h1, "armed");
      gec_ttl_model_inst.set_gate(m == 3);
      gec_ttl_model_inst.toggle(4);
      halt();
      check(count_out, 32'h2, "triggered count");
    end
  endtask
  // Internal square wave of period 4 clocks; busy pin must not count
  task automatic s_tbase();
    go(3'h0, 1'h0, 32'h2);
    pulse(start_in);
    gec_ttl_model_inst.toggle(40);
    halt();
    check(32'(count_out >= 32'h9 && count_out <= 32'hC), 32'h1, "timebase count");
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk_in          = 1'h0;
    sys_rst_in      = 1'h1;
    start_in        = 1'h0;
    stop_in         = 1'h0;
    clear_in        = 1'h0;
    gate_mode_in    = 3'h0;
    source_edge_in  = 1'h0;
    timebase_div_in = 32'h0;
    repeat (4) @(negedge clk_in);
    sys_rst_in = 1'h0;
    s_free();
    s_level();
    s_trig();
    s_tbase();
    close_out();
  end
  // Whole run needs about 170 cycles
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
endmodule // tb_gec_counter
